// >>> verilog/frac_mul_and_flow_control_exec.sv
// execution unit for fractional multiply, indirect jump/call, return,
// compares, skips and status branches
// assumes operand values, pc, Z pointer and stack top arrive from same-clock core logic
//
// How it works
// RULE_01: fractional multiplies write (rd x rr) << 1 to r1:r0, set Z and C, in 2 cycles.
// RULE_02: indirect jump loads pc from the Z pointer, keeps flags and takes 2 cycles.
// RULE_03: indirect call pushes the return address, loads pc from Z, keeps flags, 3 cycles.
// RULE_04: both returns load pc from the stack top, keep flags and take 4 cycles.
// RULE_05: compare-skip-equal skips the next instruction when both registers match.
// RULE_06: compares with immediate or with carry set Z N V C H from the difference in 1 cycle.
// RULE_07: register bit skips skip when the chosen bit is clear or set, flags untouched.
// RULE_08: io bit skips skip when the addressed io bit is 0 or 1, flags untouched.
// RULE_09: branch-on-status-set jumps to pc plus offset plus one when the chosen bit is 1.
// RULE_10: branch-on-status-clear jumps when the chosen bit is 0, 1 cycle untaken and 2 taken.
// RULE_11: carry-clear and same-or-higher branch when C is 0, 1 cycle untaken and 2 taken.
// RULE_12: a skip takes 2 cycles over a one-word, 3 over a two-word, and 1 when not taken.
// RULE_13: equal, not-equal, carry-set, lower and minus branch on Z=1, Z=0, C=1, C=1 and N=1.
module frac_mul_and_flow_control_exec (
	input  wire logic                 clk_in,
	input  wire logic                 rstn_in,
	input  wire logic                 start_in,
	input  wire exec_pkg::op_t        op_in,
	input  wire logic [7:0]           rd_val_in,
	input  wire logic [7:0]           rr_val_in,
	input  wire logic [7:0]           io_val_in,
	input  wire logic [2:0]           bit_sel_in,
	input  wire logic [6:0]           offset_in,
	input  wire logic                 next_two_word_in,
	input  wire logic [7:0]           status_register_in,
	input  wire logic [15:0]          pc_in,
	input  wire logic [15:0]          z_ptr_in,
	input  wire logic [15:0]          stack_pc_in,
	output logic                      ready_out,
	output logic                      done_out,
	output logic [15:0]               pc_out,
	output logic [15:0]               product_out,
	output logic                      product_we_out,
	output logic [7:0]                status_register_out,
	output logic                      status_we_out,
	output logic                      push_out,
	output logic                      pop_out,
	output logic [15:0]               ret_addr_out
);
	import exec_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [15:0] frac_product(input logic [7:0] a, input logic [7:0] b,
			input logic a_signed, input logic b_signed);
		logic [17:0] ax;
		logic [17:0] bx;
		logic [17:0] p;
		ax = {{10{a_signed & a[7]}}, a};
		bx = {{10{b_signed & b[7]}}, b};
		p  = ax * bx;
		return p[15:0];
	endfunction : frac_product

	function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [6:0] k);
		return pc + {{9{k[6]}}, k} + PC_STEP;
	endfunction : rel_target

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	// only the second stage drives the reset net, the first may be metastable
	assign rst_n = rst_sync_q[$left(rst_sync_q)];

	// ****************************************************************
	// decode of the offered operation
	// ****************************************************************
	logic [15:0] raw_prod;
	logic [7:0]  cmp_sub;
	logic [7:0]  cmp_diff;
	logic [7:0]  cmp_flags;
	logic        cond;
	logic        is_skip;
	logic        is_branch;
	logic [15:0] pc_d;
	logic [2:0]  cyc_d;
	logic        prod_we_d;
	logic        status_we_d;
	logic [7:0]  status_d;
	logic        push_d;
	logic        pop_d;

	always_comb begin
		raw_prod = frac_product(rd_val_in, rr_val_in,
			(op_in != OP_FRAC_MUL_UNSIGNED),
			(op_in == OP_FRAC_MUL_SIGNED));
		cmp_sub  = (op_in == OP_COMPARE_WITH_CARRY) ?
			rr_val_in + {7'h00, status_register_in[FLAG_C]} : rr_val_in;
		cmp_diff = rd_val_in - cmp_sub;
		cmp_flags = status_register_in;
		// borrow terms use the operand and carry as the core's subtract does
		cmp_flags[FLAG_H] = (~rd_val_in[3] & rr_val_in[3]) | (rr_val_in[3] & cmp_diff[3])
			| (cmp_diff[3] & ~rd_val_in[3]); // RULE_06
		cmp_flags[FLAG_V] = (rd_val_in[7] & ~rr_val_in[7] & ~cmp_diff[7])
			| (~rd_val_in[7] & rr_val_in[7] & cmp_diff[7]); // RULE_06
		cmp_flags[FLAG_N] = cmp_diff[7]; // RULE_06
		cmp_flags[FLAG_C] = (~rd_val_in[7] & rr_val_in[7]) | (rr_val_in[7] & cmp_diff[7])
			| (cmp_diff[7] & ~rd_val_in[7]); // RULE_06
		cmp_flags[FLAG_S] = cmp_flags[FLAG_N] ^ cmp_flags[FLAG_V];
		// with carry, zero can only stay set so multi-byte compares chain
		cmp_flags[FLAG_Z] = (cmp_diff == 8'h00) &
			((op_in != OP_COMPARE_WITH_CARRY) | status_register_in[FLAG_Z]); // RULE_06

		cond        = 1'b0;
		is_skip     = 1'b0;
		is_branch   = 1'b0;
		pc_d        = pc_in + PC_STEP;
		cyc_d       = CYC_ONE;
		prod_we_d   = 1'b0;
		status_we_d = 1'b0;
		status_d    = status_register_in;
		push_d      = 1'b0;
		pop_d       = 1'b0;

		case (op_in)
			OP_FRAC_MUL_UNSIGNED, OP_FRAC_MUL_SIGNED, OP_FRAC_MUL_SIGNED_UNSIGNED: begin
				prod_we_d         = 1'b1; // RULE_01
				status_we_d       = 1'b1;
				status_d[FLAG_C]  = raw_prod[15]; // RULE_01
				status_d[FLAG_Z]  = ({raw_prod[14:0], 1'b0} == 16'h0000); // RULE_01
				cyc_d             = CYC_MUL; // RULE_01
			end
			OP_INDIRECT_JUMP: begin
				pc_d  = z_ptr_in; // RULE_02
				cyc_d = CYC_JUMP; // RULE_02
			end
			OP_INDIRECT_CALL: begin
				pc_d   = z_ptr_in; // RULE_03
				push_d = 1'b1; // RULE_03
				cyc_d  = CYC_CALL; // RULE_03
			end
			OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
				pc_d  = stack_pc_in; // RULE_04
				pop_d = 1'b1; // RULE_04
				cyc_d = CYC_RETURN; // RULE_04
			end
			OP_COMPARE_SKIP_EQUAL: begin
				is_skip = 1'b1;
				cond    = (rd_val_in == rr_val_in); // RULE_05
			end
			OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
				status_we_d = 1'b1; // RULE_06
				status_d    = cmp_flags; // RULE_06
			end
			OP_SKIP_REG_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond    = ~rr_val_in[bit_sel_in]; // RULE_07
			end
			OP_SKIP_REG_BIT_SET: begin
				is_skip = 1'b1;
				cond    = rr_val_in[bit_sel_in]; // RULE_07
			end
			OP_SKIP_IO_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond    = ~io_val_in[bit_sel_in]; // RULE_08
			end
			OP_SKIP_IO_BIT_SET: begin
				is_skip = 1'b1;
				cond    = io_val_in[bit_sel_in]; // RULE_08
			end
			OP_BRANCH_STATUS_BIT_SET: begin
				is_branch = 1'b1;
				cond      = status_register_in[bit_sel_in]; // RULE_09
			end
			OP_BRANCH_STATUS_BIT_CLEAR: begin
				is_branch = 1'b1;
				cond      = ~status_register_in[bit_sel_in]; // RULE_10
			end
			OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: begin
				is_branch = 1'b1;
				cond      = ~status_register_in[FLAG_C]; // RULE_11
			end
			OP_BRANCH_EQUAL: begin
				is_branch = 1'b1;
				cond      = status_register_in[FLAG_Z]; // RULE_13
			end
			OP_BRANCH_NOT_EQUAL: begin
				is_branch = 1'b1;
				cond      = ~status_register_in[FLAG_Z]; // RULE_13
			end
			OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: begin
				is_branch = 1'b1;
				cond      = status_register_in[FLAG_C]; // RULE_13
			end
			OP_BRANCH_MINUS: begin
				is_branch = 1'b1;
				cond      = status_register_in[FLAG_N]; // RULE_13
			end
			default: begin
				cond = 1'b0;
			end
		endcase

		if (is_skip && cond) begin
			pc_d  = pc_in + (next_two_word_in ? PC_SKIP2 : PC_SKIP1); // RULE_12
			cyc_d = next_two_word_in ? CYC_SKIP2 : CYC_SKIP1; // RULE_12
		end
		if (is_branch && cond) begin
			pc_d  = rel_target(pc_in, offset_in); // RULE_09
			cyc_d = CYC_TAKEN; // RULE_10
		end
	end

	// ****************************************************************
	// sequencing
	// ****************************************************************
	state_t     state_q;
	logic [2:0] cnt_q;
	logic       take;
	logic       last;

	assign ready_out = (state_q == ST_IDLE);
	assign take      = start_in && ready_out;
	assign last      = (state_q == ST_EXEC) && (cnt_q == CNT_LAST);
	assign done_out  = last;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cnt_q   <= 3'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q <= ST_EXEC;
						cnt_q   <= cyc_d;
					end
				end
				ST_EXEC: begin
					cnt_q <= cnt_q - CNT_LAST;
					if (last) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// results, held from acceptance until the next operation
	// ****************************************************************
	logic        prod_we_q;
	logic        status_we_q;
	logic        push_q;
	logic        pop_q;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pc_out              <= 16'h0000;
			product_out         <= 16'h0000;
			status_register_out <= 8'h00;
			ret_addr_out        <= 16'h0000;
			prod_we_q           <= 1'b0;
			status_we_q         <= 1'b0;
			push_q              <= 1'b0;
			pop_q               <= 1'b0;
		end else if (take) begin
			pc_out              <= pc_d;
			product_out         <= {raw_prod[14:0], 1'b0}; // RULE_01
			status_register_out <= status_d;
			ret_addr_out        <= pc_in + PC_STEP; // RULE_03
			prod_we_q           <= prod_we_d;
			status_we_q         <= status_we_d;
			push_q              <= push_d;
			pop_q               <= pop_d;
		end
	end

	// write strobes only on the closing cycle so the core commits once
	assign product_we_out = last && prod_we_q;
	assign status_we_out  = last && status_we_q;
	assign push_out       = last && push_q;
	assign pop_out        = last && pop_q;

endmodule : frac_mul_and_flow_control_exec

// >>> verilog/exec_pkg.sv
// package for the fractional multiply and flow control execution unit
// assumes a decoder upstream that presents one decoded operation at a time
package exec_pkg;

	// ****************************************************************
	// operations
	// ****************************************************************
	typedef enum logic [4:0] {
		OP_FRAC_MUL_UNSIGNED        = 5'h00,
		OP_FRAC_MUL_SIGNED          = 5'h01,
		OP_FRAC_MUL_SIGNED_UNSIGNED = 5'h02,
		OP_INDIRECT_JUMP            = 5'h03,
		OP_INDIRECT_CALL            = 5'h04,
		OP_SUBROUTINE_RETURN        = 5'h05,
		OP_INTERRUPT_RETURN         = 5'h06,
		OP_COMPARE_SKIP_EQUAL       = 5'h07,
		OP_COMPARE_WITH_CARRY       = 5'h08,
		OP_COMPARE_IMMEDIATE        = 5'h09,
		OP_SKIP_REG_BIT_CLEAR       = 5'h0A,
		OP_SKIP_REG_BIT_SET         = 5'h0B,
		OP_SKIP_IO_BIT_CLEAR        = 5'h0C,
		OP_SKIP_IO_BIT_SET          = 5'h0D,
		OP_BRANCH_STATUS_BIT_SET    = 5'h0E,
		OP_BRANCH_STATUS_BIT_CLEAR  = 5'h0F,
		OP_BRANCH_EQUAL             = 5'h10,
		OP_BRANCH_NOT_EQUAL         = 5'h11,
		OP_BRANCH_CARRY_SET         = 5'h12,
		OP_BRANCH_CARRY_CLEAR       = 5'h13,
		OP_BRANCH_SAME_OR_HIGHER    = 5'h14,
		OP_BRANCH_LOWER             = 5'h15,
		OP_BRANCH_MINUS             = 5'h16
	} op_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} state_t;

	// ****************************************************************
	// status register bit positions
	// ****************************************************************
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	// ****************************************************************
	// cycle counts and pc steps
	// ****************************************************************
	localparam logic [2:0]  CYC_ONE     = 3'h1;
	localparam logic [2:0]  CYC_MUL     = 3'h2;
	localparam logic [2:0]  CYC_JUMP    = 3'h2;
	localparam logic [2:0]  CYC_CALL    = 3'h3;
	localparam logic [2:0]  CYC_RETURN  = 3'h4;
	localparam logic [2:0]  CYC_TAKEN   = 3'h2;
	localparam logic [2:0]  CYC_SKIP1   = 3'h2;
	localparam logic [2:0]  CYC_SKIP2   = 3'h3;
	localparam logic [15:0] PC_STEP     = 16'h0001;
	localparam logic [15:0] PC_SKIP1    = 16'h0002;
	localparam logic [15:0] PC_SKIP2    = 16'h0003;
	localparam logic [2:0]  CNT_LAST    = 3'h1;
	localparam logic [1:0]  RST_SYNC_ON = 2'h3;

endpackage : exec_pkg

// >>> sim/exec_chk.sv
// checker for the execution unit: cycle counts, pc results and strobes
// assumes it is bound to frac_mul_and_flow_control_exec, one clock domain
module exec_chk
	import exec_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        start_in,
	input wire op_t         op_in,
	input wire logic [7:0]  rr_val_in,
	input wire logic [2:0]  bit_sel_in,
	input wire logic [7:0]  status_register_in,
	input wire logic [15:0] pc_in,
	input wire logic [15:0] z_ptr_in,
	input wire logic [15:0] stack_pc_in,
	input wire logic        ready_out,
	input wire logic        done_out,
	input wire logic [15:0] pc_out,
	input wire logic        product_we_out,
	input wire logic        status_we_out,
	input wire logic        push_out,
	input wire logic        pop_out,
	input wire logic [15:0] ret_addr_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************************************
	// properties
	// ****************************************************************
	logic take;
	assign take = start_in & ready_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_mul_two: assert property (take && op_in inside {OP_FRAC_MUL_UNSIGNED,
		OP_FRAC_MUL_SIGNED, OP_FRAC_MUL_SIGNED_UNSIGNED} |=> !done_out ##1
		(done_out && product_we_out && status_we_out)) else $error("multiply timing");
	a_jump_pc: assert property (take && op_in == OP_INDIRECT_JUMP |=> !done_out ##1
		(done_out && pc_out == $past(z_ptr_in, 2) && !status_we_out)) else $error("jump");
	a_call_push: assert property (take && op_in == OP_INDIRECT_CALL |-> ##3 (done_out
		&& push_out && pc_out == $past(z_ptr_in, 3)
		&& ret_addr_out == $past(pc_in, 3) + 16'h0001)) else $error("call");
	a_ret_pop: assert property (take && op_in inside {OP_SUBROUTINE_RETURN,
		OP_INTERRUPT_RETURN} |=> !done_out [*3] ##1 (done_out && pop_out
		&& pc_out == $past(stack_pc_in, 4) && !status_we_out)) else $error("return");
	a_cmp_single: assert property (take && op_in inside {OP_COMPARE_WITH_CARRY,
		OP_COMPARE_IMMEDIATE} |=> done_out && status_we_out) else $error("compare");
	a_skip_none: assert property (take && op_in == OP_SKIP_REG_BIT_SET
		&& !rr_val_in[bit_sel_in] |=> done_out && pc_out == $past(pc_in) + 16'h0001)
		else $error("skip not taken");
	a_eq_taken: assert property (take && op_in == OP_BRANCH_EQUAL
		&& status_register_in[FLAG_Z] |=> !done_out ##1 done_out) else $error("branch");
	a_busy_hold: assert property (take |=> !ready_out)
		else $error("taken while busy");
	a_ready_back: assert property (done_out |=> ready_out && !done_out)
		else $error("ready");
	a_flag_pulse: assert property (status_we_out |-> done_out)
		else $error("flag strobe");
endmodule : exec_chk

bind frac_mul_and_flow_control_exec exec_chk i_chk (.*);

// >>> sim/core_model.sv
// core-side model: program counter and status register that follow the unit
// assumes done and the flag strobe are one-cycle pulses on clk_in
module core_model (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        done_in,
	input  wire logic        status_we_in,
	input  wire logic [15:0] pc_next_in,
	input  wire logic [7:0]  status_next_in,
	output logic      [15:0] pc_out,
	output logic      [7:0]  status_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************************************
	// state
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) pc_out <= 16'h0100;
		else if (done_in) pc_out <= pc_next_in;
	end
	// flags move only on the strobe, so kept flags show at once
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) status_out <= 8'h00;
		else if (status_we_in) status_out <= status_next_in;
	end
endmodule : core_model

// >>> sim/frac_mul_and_flow_control_exec_test.sv
// testbench for the execution unit, core model on pc and flags
// assumes one request at a time, inputs driven 2 ns after the edge
module frac_mul_and_flow_control_exec_test;
	timeunit 1ns;
	timeprecision 1ns;
	import exec_pkg::*;
	logic clk = 0, rstn = 0, start = 0, tw = 0, rdy, done, pwe, swe, push, pop;
	op_t op = OP_COMPARE_IMMEDIATE;
	logic [7:0] rd = 0, rr = 0, io = 0, st, sto;
	logic [2:0] bs = 0;
	logic [6:0] off = 7'h7E;
	logic [15:0] pc, pco, prod, ret, z = 0, stk = 0;
	int fail_count = 0, comparisons = 0;
	op_t mo[4] = '{OP_FRAC_MUL_UNSIGNED, OP_FRAC_MUL_SIGNED,
		OP_FRAC_MUL_SIGNED_UNSIGNED, OP_FRAC_MUL_UNSIGNED};
	logic [7:0] ma[4] = '{8'hFF, 8'h80, 8'hFF, 8'h00}, mb[4] = '{8'hFF, 8'h80, 8'h02, 8'h55};
	logic [15:0] mp[4] = '{16'hFC02, 16'h8000, 16'hFFFC, 16'h0000};
	logic [7:0] mf[4] = '{8'h01, 8'h00, 8'h01, 8'h02};
	op_t co[4] = '{OP_COMPARE_IMMEDIATE, OP_COMPARE_WITH_CARRY,
		OP_COMPARE_IMMEDIATE, OP_COMPARE_WITH_CARRY};
	logic [7:0] cb[4] = '{8'h20, 8'h10, 8'h10, 8'h10}, ce[4] = '{8'h15, 8'h35, 8'h02, 8'h02};
	op_t bo[9] = '{OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET,
		OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER,
		OP_BRANCH_MINUS, OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR};
	op_t so[6] = '{OP_SKIP_REG_BIT_SET, OP_SKIP_REG_BIT_SET, OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_IO_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_COMPARE_SKIP_EQUAL};
	logic [7:0] sv[6] = '{8'h80, 8'h7F, 8'hFE, 8'h08, 8'h08, 8'h5A};
	logic [2:0] sb[6] = '{3'h7, 3'h7, 3'h0, 3'h3, 3'h3, 3'h0};
	logic [5:0] s2 = 6'b001100;
	int sn[6] = '{2, 1, 3, 3, 1, 2};

	always #25 clk = ~clk;

	frac_mul_and_flow_control_exec i_dut (.clk_in(clk), .rstn_in(rstn), .start_in(start),
		.op_in(op), .rd_val_in(rd), .rr_val_in(rr), .io_val_in(io), .bit_sel_in(bs),
		.offset_in(off), .next_two_word_in(tw), .status_register_in(st), .pc_in(pc),
		.z_ptr_in(z), .stack_pc_in(stk), .ready_out(rdy), .done_out(done), .pc_out(pco),
		.product_out(prod), .product_we_out(pwe), .status_register_out(sto),
		.status_we_out(swe), .push_out(push), .pop_out(pop), .ret_addr_out(ret));
	core_model i_core (.clk_in(clk), .rstn_in(rstn), .done_in(done), .status_we_in(swe),
		.pc_next_in(pco), .status_next_in(sto), .pc_out(pc), .status_out(st));

	// ****************************************************************
	// tasks
	// ****************************************************************
	task check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	// ends one edge after done, so the model pc is current on return
	task go(input op_t o, input int n, input logic [15:0] e, input logic [3:0] s);
		int c;
		op = o;
		start = 1;
		@(posedge clk);
		#2 start = 0;
		c = 1;
		while (done !== 1'b1 && c < 8) begin
			@(posedge clk);
			#2 c++;
		end
		check(16'(c), 16'(n));
		check(pco, e);
		check(16'({pwe, swe, push, pop}), 16'(s));
		check(16'(rdy), 16'h0000);
		@(posedge clk);
		#2;
		check(16'(rdy), 16'h0001);
	endtask : go

	task br(input logic [8:0] m);
		logic [15:0] t;
		for (int j = 0; j < 9; j++) begin
			t = m[8-j] ? pc + {{9{off[6]}}, off} + 16'h0001 : pc + 16'h0001;
			go(bo[j], m[8-j] ? 2 : 1, t, 4'h0);
		end
	endtask : br

	task test_done;
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done

	initial begin
		#100000;
		fail_count++;
		test_done;
	end

	initial begin
		repeat (2) @(posedge clk);
		#2 rstn = 1;
		repeat (3) @(posedge clk);
		#2;
		for (int i = 0; i < 4; i++) begin
			rd = ma[i];
			rr = mb[i];
			go(mo[i], 2, pc + 16'h0001, 4'hC);
			check(prod, mp[i]);
			check({8'h00, sto}, {8'h00, mf[i]});
		end
		z = 16'h1234;
		go(OP_INDIRECT_JUMP, 2, z, 4'h0);
		z = 16'h0400;
		go(OP_INDIRECT_CALL, 3, z, 4'h2);
		check(ret, 16'h1235);
		stk = 16'h0ABC;
		go(OP_SUBROUTINE_RETURN, 4, stk, 4'h1);
		stk = 16'h0777;
		go(OP_INTERRUPT_RETURN, 4, stk, 4'h1);
		// flag states feed the branch passes through the model
		for (int i = 0; i < 4; i++) begin
			rd = 8'h10;
			rr = cb[i];
			go(co[i], 1, pc + 16'h0001, 4'h4);
			check({8'h00, sto}, {8'h00, ce[i]});
			if (i == 0) br(9'b011001110);
			if (i == 3) br(9'b100110001);
		end
		for (int i = 0; i < 6; i++) begin
			rd = sv[i];
			rr = sv[i];
			io = sv[i];
			bs = sb[i];
			tw = s2[5-i];
			go(so[i], sn[i], pc + 16'(sn[i]), 4'h0);
		end
		test_done;
	end
endmodule : frac_mul_and_flow_control_exec_test
